// ==== rtl/psm_top.sv ====
// power-up sequencer and supply monitor with AXI4-Lite registers
// assumes supply comparator and nonvolatile inputs synchronous to aclk
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module psm_top (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          vbat_ok,
	input  wire logic          ldo_ok,
	input  wire logic          supply_uv,
	input  wire logic          supply_low,
	input  wire logic          open_fault,
	input  wire logic          short_fault,
	input  wire logic [3:0]    nv_startup_timer_length,
	input  wire logic [4:0]    nv_low_supply_threshold,
	input  wire logic [1:0]    nv_current_range_select,
	output logic [23:0]        channel_output,
	output logic [143:0]       channel_current_code,
	output logic [1:0]         current_range_select,
	output logic [4:0]         low_supply_threshold,
	output logic               fault_pin_out,
	output logic               fault_pin_oe,
	output logic               irq
);
	psm_pkg::psm_regs_t q;       // registered state
	psm_pkg::psm_regs_t d;       // next state
	psm_seq_if          sif ();  // link to the sequencer
	logic               in_por;  // lockout or sequencer reset
	logic               wr_fire; // write performed this cycle
	logic [5:0]         wr_idx;  // write word index
	logic [5:0]         rd_idx;  // read word index
	logic               ar_take; // read address taken
	logic [5:0]         evt;     // flag set events this cycle
	logic [5:0]         clr;     // flag clears this cycle
	logic [31:0]        cfg_w;   // config word with write merged

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// true when a word index maps to a register
	function automatic logic mapped(input logic [5:0] idx);
		logic ok;
		ok = (idx <= psm_pkg::OFS_ENABLE[7:2])
			|| (idx >= psm_pkg::OFS_CODE0[7:2]
			&& idx < psm_pkg::OFS_CODE0[7:2] + 6'(psm_pkg::NUM_CH));
		return ok;
	endfunction

	// sequencer
	psm_seq u_seq (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sif     (sif)
	);

	assign sif.supplies_ok = vbat_ok && ldo_ok;
	assign sif.timer_len   = q.tlen;
	assign sif.clr_por     = q.clr_pulse;

	// reset state holds while a supply is low or sequencer restarts
	assign in_por  = !sif.supplies_ok
		|| (sif.state == psm_pkg::PSM_POR);
	assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
	assign wr_idx  = q.awaddr[7:2];
	assign rd_idx  = s_axi_araddr[7:2];
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// next state of bus slave, flags and settings
	always_comb begin
		d = q;
		d.clr_pulse = 1'b0;
		evt = 6'h00;
		clr = 6'h00;
		cfg_w = merge({16'h0, q.tlen, 2'h0, q.range, 3'h0, q.low_th},
			q.wdata, q.wstrb);
		// write address and data, taken in any order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_have = 1'b1;
			d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_have = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		// write effects
		if (wr_fire) begin
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = mapped(wr_idx) ? psm_pkg::RESP_OKAY
				: psm_pkg::RESP_SLV;
			if (q.awaddr[7:2] == psm_pkg::OFS_CTRL[7:2] && q.wstrb[0]) begin
				if (q.wdata[psm_pkg::CTRL_POR_CLEAR]) begin
					clr[psm_pkg::ST_POR] = 1'b1;
					d.clr_pulse = 1'b1;
				end
				if (q.wdata[psm_pkg::CTRL_FCLR]) begin
					// fault flags and summary error
					clr = clr | 6'h3E;
				end
				if (q.wdata[psm_pkg::CTRL_RELOAD]) begin
					// bit is an action: reads back as zero
					clr[psm_pkg::ST_POR] = 1'b1;
					d.low_th = nv_low_supply_threshold;
					d.range  = nv_current_range_select;
					d.tlen   = nv_startup_timer_length;
					d.mask   = psm_pkg::MASK_RST;
					d.enable = psm_pkg::ENABLE_RST;
					d.code   = {psm_pkg::NUM_CH{psm_pkg::CODE_RST}};
				end
			end else if (q.awaddr[7:2] == psm_pkg::OFS_STATUS[7:2]) begin
				// write one to clear
				clr = clr | 6'(merge(32'h0, q.wdata, q.wstrb));
			end else if (q.awaddr[7:2] == psm_pkg::OFS_MASK[7:2]) begin
				d.mask = 6'(merge({26'h0, q.mask}, q.wdata, q.wstrb));
			end else if (q.awaddr[7:2] == psm_pkg::OFS_CONFIG[7:2]) begin
				// threshold code 0 = 4V, step 1V, 32 codes
				d.low_th = cfg_w[psm_pkg::CF_TH_LSB +: 5];
				d.range  = cfg_w[psm_pkg::CF_RANGE_LSB +: 2];
				d.tlen   = cfg_w[psm_pkg::CF_TLEN_LSB +: 4];
			end else if (q.awaddr[7:2] == psm_pkg::OFS_ENABLE[7:2]) begin
				d.enable = 24'(merge({8'h0, q.enable}, q.wdata, q.wstrb));
			end else if (mapped(wr_idx) && wr_idx >= psm_pkg::OFS_CODE0[7:2])
			begin
				// one six-bit code per word
				d.code[5'(wr_idx - psm_pkg::OFS_CODE0[7:2])] = 6'(merge(
					{26'h0, q.code[5'(wr_idx - psm_pkg::OFS_CODE0[7:2])]},
					q.wdata, q.wstrb));
			end
		end
		// read channel, one outstanding
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (ar_take) begin
			d.rvalid = 1'b1;
			d.rresp  = mapped(rd_idx) ? psm_pkg::RESP_OKAY
				: psm_pkg::RESP_SLV;
			d.rdata  = 32'h0;
			if (rd_idx == psm_pkg::OFS_STATUS[7:2]) begin
				d.rdata = {26'h0, q.status};
			end else if (rd_idx == psm_pkg::OFS_MASK[7:2]) begin
				d.rdata = {26'h0, q.mask};
			end else if (rd_idx == psm_pkg::OFS_CONFIG[7:2]) begin
				d.rdata = {14'h0, sif.state, q.tlen, 2'h0, q.range,
					3'h0, q.low_th};
			end else if (rd_idx == psm_pkg::OFS_ENABLE[7:2]) begin
				d.rdata = {8'h0, q.enable};
			end else if (mapped(rd_idx)
				&& rd_idx >= psm_pkg::OFS_CODE0[7:2]) begin
				d.rdata = {26'h0,
					q.code[5'(rd_idx - psm_pkg::OFS_CODE0[7:2])]};
			end
		end
		// supply events; low supply blocks open and short
		evt[psm_pkg::ST_UV]    = supply_uv;
		evt[psm_pkg::ST_LOW]   = supply_low;
		evt[psm_pkg::ST_OPEN]  = open_fault && !supply_low;
		evt[psm_pkg::ST_SHORT] = short_fault && !supply_low;
		evt[psm_pkg::ST_ERR]   = |evt[5:2];
		if (supply_low) begin
			clr = clr | 6'h30;
		end
		// sets win over clears
		d.status = (q.status & ~clr) | evt;
		// output drive: off unless running and supply good
		d.chan_out = (sif.state == psm_pkg::PSM_RUN && !supply_uv
			&& !in_por) ? q.enable : 24'h000000;
		d.fault_oe = in_por || supply_uv;
		// lockout: core reset and nonvolatile load
		if (in_por) begin
			d.status  = psm_pkg::STATUS_RST | evt;
			d.mask    = psm_pkg::MASK_RST;
			d.low_th  = nv_low_supply_threshold;
			d.range   = nv_current_range_select;
			d.tlen    = nv_startup_timer_length;
			d.enable  = psm_pkg::ENABLE_RST;
			d.code    = {psm_pkg::NUM_CH{psm_pkg::CODE_RST}};
			d.chan_out = 24'h000000;
			d.clr_pulse = 1'b0;
		end
	end

	// state register; bus reset only by aresetn
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q.aw_have   <= 1'b0;
			q.w_have    <= 1'b0;
			q.awaddr    <= 8'h00;
			q.wdata     <= 32'h0;
			q.wstrb     <= 4'h0;
			q.bvalid    <= 1'b0;
			q.bresp     <= psm_pkg::RESP_OKAY;
			q.rvalid    <= 1'b0;
			q.rresp     <= psm_pkg::RESP_OKAY;
			q.rdata     <= 32'h0;
			q.status    <= psm_pkg::STATUS_RST;
			q.mask      <= psm_pkg::MASK_RST;
			q.low_th    <= 5'h00;
			q.range     <= 2'h3;
			q.tlen      <= 4'h0;
			q.enable    <= psm_pkg::ENABLE_RST;
			q.code      <= {psm_pkg::NUM_CH{psm_pkg::CODE_RST}};
			q.chan_out  <= 24'h000000;
			q.fault_oe  <= 1'b1;
			q.clr_pulse <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// bus handshakes
	assign s_axi_awready = !q.aw_have && !q.bvalid;
	assign s_axi_wready  = !q.w_have && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;

	// block outputs
	assign channel_output       = q.chan_out;
	assign channel_current_code = q.code;
	assign current_range_select = q.range;
	assign low_supply_threshold = q.low_th;
	assign fault_pin_out        = 1'b0;  // open drain pulls low only
	assign fault_pin_oe         = q.fault_oe;
	assign irq                  = |(q.status & q.mask);

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence clr_in_init;
		sif.state == psm_pkg::PSM_INIT && q.clr_pulse && sif.supplies_ok;
	endsequence

	sequence reload_write;
		wr_fire && wr_idx == psm_pkg::OFS_CTRL[7:2] && q.wstrb[0]
			&& q.wdata[psm_pkg::CTRL_RELOAD] && !in_por;
	endsequence

	por_flags_a: assert property (in_por |=>
		q.status[psm_pkg::ST_POR] && q.status[psm_pkg::ST_ERR])
		else $error("power-on flags not set in reset");
	por_outputs_a: assert property (in_por |=>
		channel_output == 24'h0 && fault_pin_oe && q.enable == 24'h0)
		else $error("outputs active during reset");
	init_release_a: assert property (
		(sif.state == psm_pkg::PSM_INIT && sif.supplies_ok && !supply_uv)
		|=> !fault_pin_oe)
		else $error("fault pin held in start-up");
	clr_por_run_a: assert property (clr_in_init |=>
		sif.state == psm_pkg::PSM_RUN)
		else $error("power-on clear did not end start-up");
	reload_nv_a: assert property (reload_write |=>
		q.range == $past(nv_current_range_select)
		&& !q.status[psm_pkg::ST_POR] && q.enable == 24'h0)
		else $error("reload defaults failed");
	uv_shutdown_a: assert property (supply_uv |=>
		channel_output == 24'h0 && fault_pin_oe
		&& q.status[psm_pkg::ST_UV] && q.status[psm_pkg::ST_ERR])
		else $error("undervoltage did not shut outputs");
	low_flag_a: assert property (supply_low |=>
		q.status[psm_pkg::ST_LOW] && q.status[psm_pkg::ST_ERR])
		else $error("low supply flag missing");
	low_blocks_a: assert property (supply_low |=>
		!q.status[psm_pkg::ST_OPEN] && !q.status[psm_pkg::ST_SHORT])
		else $error("open or short fault kept under low supply");
	lockout_exit_a: assert property (!sif.supplies_ok |=>
		sif.state == psm_pkg::PSM_POR)
		else $error("lockout did not return to reset");
endmodule

// ==== rtl/psm_pkg.sv ====
// constants and types of the power-up sequencer and supply monitor
// assumes a 100 MHz aclk and word-aligned AXI4-Lite register access
package psm_pkg;
	localparam int          CLK_PERIOD_NS    = 10;   // aclk period
	localparam int          STARTUP_TICK_NS  = 1000; // start-up timer step
	localparam int          STARTUP_TICK_CYC = STARTUP_TICK_NS / CLK_PERIOD_NS;
	localparam int          NUM_CH           = 24;   // channel count
	localparam int          LOW_TH_BASE_V    = 4;    // threshold code 0 volts
	localparam int          LOW_TH_STEP_V    = 1;    // volts per code step
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;  // action bits
	localparam logic [7:0]  OFS_STATUS = 8'h04;  // sticky flags, w1c
	localparam logic [7:0]  OFS_MASK   = 8'h08;  // interrupt mask
	localparam logic [7:0]  OFS_CONFIG = 8'h0C;  // threshold, range, timer
	localparam logic [7:0]  OFS_ENABLE = 8'h10;  // channel enables
	localparam logic [7:0]  OFS_CODE0  = 8'h20;  // first current code
	// control bit positions
	localparam int          CTRL_POR_CLEAR = 0;  // power_on_flag_clear
	localparam int          CTRL_RELOAD  = 1;  // reload_defaults
	localparam int          CTRL_FCLR    = 2;  // fault_clear
	// status bit positions
	localparam int          ST_POR   = 0;  // power-on history
	localparam int          ST_ERR   = 1;  // summary error
	localparam int          ST_UV    = 2;  // supply_undervoltage_flag
	localparam int          ST_LOW   = 3;  // low_supply_warning_flag
	localparam int          ST_OPEN  = 4;  // led open fault
	localparam int          ST_SHORT = 5;  // single-led short fault
	// config field positions
	localparam int          CF_TH_LSB    = 0;   // low_supply_threshold
	localparam int          CF_RANGE_LSB = 8;   // current_range_select
	localparam int          CF_TLEN_LSB  = 12;  // startup_timer_length
	localparam int          CF_STATE_LSB = 16;  // sequencer state, read only
	// values after reset
	localparam logic [5:0]  STATUS_RST = 6'h03;   // por and err set
	localparam logic [5:0]  MASK_RST   = 6'h00;
	localparam logic [23:0] ENABLE_RST = 24'h000000;
	localparam logic [5:0]  CODE_RST   = 6'h00;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	// sequencer states, gray along por -> init -> run
	typedef enum logic [1:0] {
		PSM_POR  = 2'h0,
		PSM_INIT = 2'h1,
		PSM_RUN  = 2'h3
	} psm_state_t;

	// sequencer state
	typedef struct packed {
		psm_state_t  st;   // current state
		logic [11:0] cnt;  // start-up timer
	} psm_seq_t;

	// register file and bus slave state
	typedef struct packed {
		logic             aw_have;   // write address held
		logic             w_have;    // write data held
		logic [7:0]       awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic [5:0]       status;    // sticky flags
		logic [5:0]       mask;      // interrupt mask
		logic [4:0]       low_th;    // low supply threshold
		logic [1:0]       range;     // current range select
		logic [3:0]       tlen;      // start-up timer length
		logic [23:0]      enable;    // channel enables
		logic [23:0][5:0] code;      // channel current codes
		logic [23:0]      chan_out;  // channel output drive
		logic             fault_oe;  // fault pin pull-down
		logic             clr_pulse; // clear request to sequencer
	} psm_regs_t;
endpackage

// ==== rtl/psm_seq_if.sv ====
// signals between the register file and the sequencer
// assumes both ends run on the same aclk
`timescale 1ns/100ps
interface psm_seq_if;
	logic                supplies_ok;  // both supplies above lockout
	logic [3:0]          timer_len;    // start-up timer length code
	logic                clr_por;      // power-on flag clear pulse
	psm_pkg::psm_state_t state;        // sequencer state

	modport regs (output supplies_ok, output timer_len, output clr_por,
		input state);
	modport seq (input supplies_ok, input timer_len, input clr_por,
		output state);
endinterface

// ==== rtl/psm_seq.sv ====
// power-up sequencer: reset, start-up wait and operating states
// assumes clr_por is a one-cycle pulse from the register file
`timescale 1ns/100ps
module psm_seq (
	input  wire logic aclk,
	input  wire logic aresetn,
	psm_seq_if.seq    sif
);
	psm_pkg::psm_seq_t q;      // registered state
	psm_pkg::psm_seq_t d;      // next state
	logic [11:0]       limit;  // start-up length in cycles

	// timer length scales with the stored code
	assign limit = 12'((16'(sif.timer_len) + 16'h1)
		* 16'(psm_pkg::STARTUP_TICK_CYC));

	// next state
	always_comb begin
		d = q;
		case (q.st)
			psm_pkg::PSM_POR: begin
				d.cnt = 12'h000;
				if (sif.supplies_ok) begin
					d.st = psm_pkg::PSM_INIT;
				end
			end
			psm_pkg::PSM_INIT: begin
				if (sif.clr_por) begin
					d.st = psm_pkg::PSM_RUN;
				end else if (q.cnt >= limit - 12'h001) begin
					d.st = psm_pkg::PSM_RUN;
				end else begin
					d.cnt = q.cnt + 12'h001;
				end
			end
			psm_pkg::PSM_RUN: begin
				d.cnt = 12'h000;
			end
			default: begin
				d.st = psm_pkg::PSM_POR;
			end
		endcase
		// lockout from any state
		if (!sif.supplies_ok) begin
			d.st  = psm_pkg::PSM_POR;
			d.cnt = 12'h000;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q.st  <= psm_pkg::PSM_POR;
			q.cnt <= 12'h000;
		end else begin
			q <= d;
		end
	end

	assign sif.state = q.st;
endmodule

// ==== dv/psm_host.sv ====
// host model: axi4-lite master doing one register access at a time
// assumes a slave on the same aclk; the bench calls wr and rd
`timescale 1ns/100ps
module psm_host (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic [2:0]       s_axi_awprot,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic [2:0]       s_axi_arprot,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus from time zero
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid} = '0;
		{s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
	end
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic b;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				b = 1'b1;
			end
		end
	endtask
	// read: rready held until the data beat arrives
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic b;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				b = 1'b1;
			end
		end
	endtask
endmodule

// ==== dv/psm_top_bench.sv ====
// bench for the sequencer and supply monitor, register-level tests
// assumes psm_host as bus master and comparator inputs driven here
`timescale 1ns/100ps
module psm_top_bench;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, nv_startup_timer_length;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, nv_current_range_select;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, fault_pin_out, fault_pin_oe, irq;
	logic vbat_ok, ldo_ok, supply_uv, supply_low, open_fault, short_fault;
	logic [4:0] nv_low_supply_threshold, low_supply_threshold;
	logic [23:0] channel_output;
	logic [143:0] channel_current_code;
	logic [1:0] current_range_select;
	int bad_count, num_checks;

	psm_top DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.vbat_ok(vbat_ok), .ldo_ok(ldo_ok), .supply_uv(supply_uv),
		.supply_low(supply_low), .open_fault(open_fault),
		.short_fault(short_fault),
		.nv_startup_timer_length(nv_startup_timer_length),
		.nv_low_supply_threshold(nv_low_supply_threshold),
		.nv_current_range_select(nv_current_range_select),
		.channel_output(channel_output),
		.channel_current_code(channel_current_code),
		.current_range_select(current_range_select),
		.low_supply_threshold(low_supply_threshold),
		.fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
		.irq(irq)
	);
	psm_host host (
		.aclk(aclk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// end of run with counts
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, far above the ~450 cycles of the sequence
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// pin check at the falling edge, where flops have settled
	task automatic pin(input logic [31:0] g, input logic [31:0] e);
		@(negedge aclk);
		chk(g, e);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		host.rd(a, rv, rr);
		chk(rv, e);
		chk({30'h0, rr}, {30'h0, er});
	endtask
	task automatic rok(input logic [7:0] a, input logic [31:0] e);
		rchk(a, e, psm_pkg::RESP_OKAY);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.wr(a, d, rr);
		chk({30'h0, rr}, {30'h0, psm_pkg::RESP_OKAY});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// expected config word: state, timer, range, threshold
	function automatic logic [31:0] cfg(input int s, input int t,
		input int g, input int h);
		return {14'h0, 2'(s), 4'(t), 2'h0, 2'(g), 3'h0, 5'(h)};
	endfunction

	initial begin
		aresetn = 1'b0;
		{vbat_ok, ldo_ok, supply_uv, supply_low} = 4'h0;
		{open_fault, short_fault} = 2'h0;
		nv_startup_timer_length = 4'h1;
		nv_low_supply_threshold = 5'h0A;
		nv_current_range_select = 2'h3;
		bad_count = 0;
		num_checks = 0;
		cyc(10);
		aresetn <= 1'b1;
		// supplies still under lockout: held in reset state
		pin({31'h0, fault_pin_oe}, 32'h1);
		pin({8'h0, channel_output}, 32'h0);
		pin({31'h0, fault_pin_out}, 32'h0);
		rok(psm_pkg::OFS_STATUS, 32'h3);
		rok(psm_pkg::OFS_CONFIG, cfg(0, 1, 3, 5'h0A));
		wr(psm_pkg::OFS_ENABLE, 32'hFF);
		rok(psm_pkg::OFS_ENABLE, 32'h0);
		// supplies good: start-up wait, timer of 2 ticks
		@(posedge aclk);
		vbat_ok <= 1'b1;
		ldo_ok  <= 1'b1;
		cyc(3);
		pin({31'h0, fault_pin_oe}, 32'h0);
		rok(psm_pkg::OFS_CONFIG, cfg(1, 1, 3, 5'h0A));
		cyc(150);
		rok(psm_pkg::OFS_CONFIG, cfg(1, 1, 3, 5'h0A));
		cyc(60);
		rok(psm_pkg::OFS_CONFIG, cfg(3, 1, 3, 5'h0A));
		// reload defaults from changed stored values
		wr(psm_pkg::OFS_CONFIG, cfg(0, 2, 1, 5'h03));
		wr(psm_pkg::OFS_ENABLE, 32'h5);
		nv_low_supply_threshold <= 5'h07;
		wr(psm_pkg::OFS_CTRL, 32'h2);
		rok(psm_pkg::OFS_CONFIG, cfg(3, 1, 3, 5'h07));
		rok(psm_pkg::OFS_ENABLE, 32'h0);
		rok(psm_pkg::OFS_STATUS, 32'h2);
		rok(psm_pkg::OFS_CTRL, 32'h0);
		wr(psm_pkg::OFS_CTRL, 32'h4);
		rok(psm_pkg::OFS_STATUS, 32'h0);
		// first and last channel, enable and current code
		wr(psm_pkg::OFS_ENABLE, 32'h800001);
		wr(psm_pkg::OFS_CODE0, 32'h15);
		wr(psm_pkg::OFS_CODE0 + 8'h5C, 32'h3F);
		pin({8'h0, channel_output}, 32'h800001);
		pin({26'h0, channel_current_code[5:0]}, 32'h15);
		pin({26'h0, channel_current_code[143:138]}, 32'h3F);
		rok(psm_pkg::OFS_CODE0 + 8'h5C, 32'h3F);
		// every range code; threshold field is five bits only
		for (int i = 0; i < 4; i++) begin
			wr(psm_pkg::OFS_CONFIG, cfg(0, 1, i[1:0], 5'h1F) | 32'hE0);
			pin({30'h0, current_range_select}, 32'(i));
			pin({27'h0, low_supply_threshold}, 32'h1F);
			rok(psm_pkg::OFS_CONFIG, cfg(3, 1, i[1:0], 5'h1F));
		end
		// unmapped offset
		host.wr(8'h14, 32'h1, rr);
		chk({30'h0, rr}, {30'h0, psm_pkg::RESP_SLV});
		rchk(8'h14, 32'h0, psm_pkg::RESP_SLV);
		// open fault, then low supply clears and blocks it
		open_fault <= 1'b1;
		cyc(2);
		rok(psm_pkg::OFS_STATUS, 32'h12);
		supply_low <= 1'b1;
		cyc(3);
		rok(psm_pkg::OFS_STATUS, 32'h0A);
		supply_low <= 1'b0;
		open_fault <= 1'b0;
		wr(psm_pkg::OFS_CTRL, 32'h4);
		rok(psm_pkg::OFS_STATUS, 32'h0);
		// short fault pulse, cleared by write-one
		short_fault <= 1'b1;
		cyc(1);
		short_fault <= 1'b0;
		rok(psm_pkg::OFS_STATUS, 32'h22);
		wr(psm_pkg::OFS_STATUS, 32'h22);
		rok(psm_pkg::OFS_STATUS, 32'h0);
		// interrupt: raise, mask, unmask, clear
		wr(psm_pkg::OFS_MASK, 32'h08);
		pin({31'h0, irq}, 32'h0);
		supply_low <= 1'b1;
		cyc(1);
		supply_low <= 1'b0;
		cyc(2);
		pin({31'h0, irq}, 32'h1);
		wr(psm_pkg::OFS_MASK, 32'h0);
		pin({31'h0, irq}, 32'h0);
		wr(psm_pkg::OFS_MASK, 32'h08);
		pin({31'h0, irq}, 32'h1);
		wr(psm_pkg::OFS_STATUS, 32'h0A);
		pin({31'h0, irq}, 32'h0);
		// led supply undervoltage
		supply_uv <= 1'b1;
		cyc(3);
		pin({8'h0, channel_output}, 32'h0);
		pin({31'h0, fault_pin_oe}, 32'h1);
		rok(psm_pkg::OFS_STATUS, 32'h06);
		supply_uv <= 1'b0;
		cyc(3);
		pin({8'h0, channel_output}, 32'h800001);
		pin({31'h0, fault_pin_oe}, 32'h0);
		wr(psm_pkg::OFS_STATUS, 32'h06);
		// lockout while operating
		ldo_ok <= 1'b0;
		cyc(3);
		pin({8'h0, channel_output}, 32'h0);
		pin({31'h0, fault_pin_oe}, 32'h1);
		rok(psm_pkg::OFS_CONFIG, cfg(0, 1, 3, 5'h07));
		rok(psm_pkg::OFS_ENABLE, 32'h0);
		rok(psm_pkg::OFS_STATUS, 32'h3);
		// longest timer, cut short by power-on clear
		nv_startup_timer_length <= 4'hF;
		cyc(2);
		ldo_ok <= 1'b1;
		cyc(5);
		rok(psm_pkg::OFS_CONFIG, cfg(1, 4'hF, 3, 5'h07));
		wr(psm_pkg::OFS_CTRL, 32'h1);
		cyc(2);
		rok(psm_pkg::OFS_CONFIG, cfg(3, 4'hF, 3, 5'h07));
		rok(psm_pkg::OFS_STATUS, 32'h2);
		give_verdict();
	end
endmodule
